// *** hdl/clk_switch_params.svh ***
/*
 * Named constants for the system clock switch: register indices, field
 * positions, reset values, encodings and timing figures.
 * Assumes it is included by bare name and holds definitions only.
 */
`ifndef CLK_SWITCH_PARAMS_SVH
`define CLK_SWITCH_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices and field positions
// ----------------------------------------------------------------------
`define CTRL_ADDR 4'h0
`define STAT_ADDR 4'h1
`define SEL_MSB 1
`define SEL_LSB 0
`define FREQ_MSB 6
`define FREQ_LSB 3
`define STAT_HF_READY_BIT 4
`define STAT_LF_READY_BIT 1
`define STAT_HF_STABLE_BIT 0

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define SEL_RESET 2'h0
`define FREQ_RESET 4'h7
`define SEL_CONFIG 2'h0
`define SEL_RSVD 2'h1
`define CFG_INTERNAL 2'h0
`define LF_CODE_HI 3'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CORE_CLK_MHZ 40
`define HF_STARTUP_NS 2000
`define BOOT_TICKS 2'h2

`endif

// *** hdl/clk_switch_pkg.sv ***
/*
 * Types shared by the system clock switch modules.
 * Assumes the params header is available to whoever needs the numbers.
 */
package clk_switch_pkg;

    // ------------------------------------------------------------------
    // Clock sources and switch sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {src_ext, src_hf, src_lf} clk_src_type;

    typedef enum logic [2:0] {st_boot, st_run, st_startup, st_wait_new, st_edge} sw_state_type;

endpackage

// *** hdl/div_link.sv ***
/*
 * Carrier between the clock switch and its high-frequency postscaler.
 * Assumes both ends run on core_clk.
 */
`timescale 1ns/1ps

interface div_link;
    logic hf_tick;
    logic [3:0] shift;
    logic div_tick;

    modport scaler (input hf_tick, input shift, output div_tick);
    modport user (output hf_tick, output shift, input div_tick);
endinterface

// *** hdl/hf_postscaler.sv ***
/*
 * Postscaler for the high-frequency oscillator ticks: divides by two to
 * the power of the requested shift and gives one registered tick pulse.
 * Assumes hf_tick is a one-cycle enable synchronous to core_clk.
 */
`timescale 1ns/1ps

module hf_postscaler #(
    parameter int CNT_W = 9
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    div_link.scaler dl
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W:0] prefix;
    logic div_tick_q;

    // ------------------------------------------------------------------
    // All-ones prefix chain: stage i fires when the low i bits are set.
    // ------------------------------------------------------------------
    assign prefix[0] = 1'b1;
    for (genvar i = 0; i < CNT_W; i++) begin : g_prefix
        assign prefix[i+1] = prefix[i] & cnt_q[i];
    end

    // Free-running counter so that a same-source divider change needs no restart.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (dl.hf_tick) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Shifts above the counter width would index past the chain, so they stop.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_tick_q <= 1'b0;
        end else begin
            div_tick_q <= dl.hf_tick && (dl.shift <= CNT_W) && prefix[dl.shift];
        end
    end

    assign dl.div_tick = div_tick_q;
endmodule

// *** hdl/clk_switch.sv ***
/*
 * System clock source selection and switch sequencer with its control
 * and status registers. Each oscillator is seen as a one-cycle tick
 * enable marking its falling edge; the selected one drives sys_clk_tick.
 * Assumes all inputs are synchronous to core_clk and that the register
 * master never issues read and write in the same cycle.
 */
`timescale 1ns/1ps
`include "clk_switch_params.svh"

module clk_switch #(
    parameter int WAIT_W = 8
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] config_osc_select,
    input wire logic ext_clk_tick,
    input wire logic hf_osc_tick,
    input wire logic lf_osc_tick,
    input wire logic hf_osc_ready_in,
    input wire logic hf_osc_stable_in,
    input wire logic lf_osc_ready_in,
    output logic sys_clk_tick,
    output clk_switch_pkg::clk_src_type active_source,
    output logic switch_busy,
    output logic hf_osc_enable,
    output logic lf_osc_enable
);
    import clk_switch_pkg::*;

    // Least start-up time into the fast oscillator, rounded up to cycles.
    localparam int HF_STARTUP_CYC = (`HF_STARTUP_NS * `CORE_CLK_MHZ + 999) / 1000;
    localparam int STARTUP_LAST = HF_STARTUP_CYC - 1;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    logic [1:0] sel_q;
    logic [3:0] freq_q;
    logic [7:0] rdata_q;
    logic ctrl_sel;
    logic stat_sel;
    logic ctrl_wr;
    logic [7:0] ctrl_val;
    logic [7:0] stat_val;
    logic [7:0] rdata_d;

    assign ctrl_sel = (reg_addr == `CTRL_ADDR);
    assign stat_sel = (reg_addr == `STAT_ADDR);
    assign ctrl_wr = reg_wr & ctrl_sel;
    // Unused control bits are tied low, so writes to them vanish.
    assign ctrl_val = {1'b0, freq_q, 1'b0, sel_q};
    assign rdata_d = !reg_rd ? 8'h00 : ctrl_sel ? ctrl_val : stat_sel ? stat_val : 8'h00;

    // Status bits are live oscillator flags; nothing here can write them.
    always_comb begin
        stat_val = 8'h00;
        stat_val[`STAT_HF_READY_BIT] = hf_osc_ready_in;
        stat_val[`STAT_LF_READY_BIT] = lf_osc_ready_in;
        stat_val[`STAT_HF_STABLE_BIT] = hf_osc_stable_in;
    end

    // Control fields clear to their documented values on every reset.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_q <= `SEL_RESET;
            freq_q <= `FREQ_RESET;
        end else if (ctrl_wr) begin
            sel_q <= reg_wdata[`SEL_MSB:`SEL_LSB];
            freq_q <= reg_wdata[`FREQ_MSB:`FREQ_LSB];
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------
    // Target source decode
    // ------------------------------------------------------------------
    function automatic logic [3:0] shift_of(input logic [3:0] code);
        unique case (code)
            4'hF: shift_of = 4'h0;
            4'hE: shift_of = 4'h1;
            4'hD: shift_of = 4'h2;
            4'hC: shift_of = 4'h3;
            4'hB: shift_of = 4'h4;
            4'hA, 4'h7: shift_of = 4'h5;
            4'h9, 4'h6: shift_of = 4'h6;
            4'h8, 4'h5: shift_of = 4'h7;
            4'h4: shift_of = 4'h8;
            default: shift_of = 4'h9;
        endcase
    endfunction

    clk_src_type want_src;
    clk_src_type tgt_src;
    clk_src_type last_src_q;
    logic [3:0] want_shift;
    logic [3:0] tgt_shift;
    logic [3:0] last_shift_q;
    logic want_internal;
    logic lf_code;
    logic hold;

    assign want_internal = sel_q[1] |
        ((sel_q == `SEL_CONFIG) & (config_osc_select == `CFG_INTERNAL));
    assign lf_code = (freq_q[3:1] == `LF_CODE_HI);
    assign want_src = !want_internal ? src_ext : lf_code ? src_lf : src_hf;
    assign want_shift = shift_of(freq_q);
    assign hold = (sel_q == `SEL_RSVD);
    // The reserved select keeps whatever was last asked for.
    assign tgt_src = hold ? last_src_q : want_src;
    assign tgt_shift = hold ? last_shift_q : want_shift;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            last_src_q <= src_hf;
            last_shift_q <= 4'h0;
        end else begin
            last_src_q <= tgt_src;
            last_shift_q <= tgt_shift;
        end
    end

    // ------------------------------------------------------------------
    // Postscaler and tick selection
    // ------------------------------------------------------------------
    div_link dl ();
    clk_src_type cur_src_q;
    clk_src_type pend_src_q;
    logic [3:0] cur_shift_q;
    logic [3:0] pend_shift_q;
    logic cur_tick;
    logic new_tick;
    logic changed;

    assign dl.hf_tick = hf_osc_tick;
    assign dl.shift = cur_shift_q;

    hf_postscaler #(.CNT_W(9)) u_scaler (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .dl(dl)
    );

    assign cur_tick = (cur_src_q == src_ext) ? ext_clk_tick :
        (cur_src_q == src_lf) ? lf_osc_tick : dl.div_tick;
    assign new_tick = (pend_src_q == src_ext) ? ext_clk_tick : lf_osc_tick;
    assign changed = (tgt_src != cur_src_q) | (tgt_src == src_hf && tgt_shift != cur_shift_q);

    // ------------------------------------------------------------------
    // Switch sequencer
    // ------------------------------------------------------------------
    sw_state_type state_q;
    logic [WAIT_W-1:0] wait_cnt_q;
    logic [1:0] boot_cnt_q;
    logic sys_tick_q;
    logic hf_en_q;
    logic lf_en_q;

    // The old clock keeps running through the wait, so the core never stalls.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= st_boot;
            cur_src_q <= src_hf;
            cur_shift_q <= 4'h0;
            pend_src_q <= src_hf;
            pend_shift_q <= 4'h0;
            wait_cnt_q <= '0;
            boot_cnt_q <= 2'h0;
        end else begin
            unique case (state_q)
                st_boot: begin
                    cur_src_q <= tgt_src;
                    cur_shift_q <= tgt_shift;
                    if (cur_tick) begin
                        boot_cnt_q <= boot_cnt_q + 2'h1;
                    end
                    if (cur_tick && boot_cnt_q == `BOOT_TICKS - 2'h1) begin
                        state_q <= st_run;
                    end
                end
                st_run: begin
                    pend_src_q <= tgt_src;
                    pend_shift_q <= tgt_shift;
                    wait_cnt_q <= '0;
                    if (changed && tgt_src == cur_src_q) begin
                        state_q <= st_edge;
                    end else if (changed && tgt_src == src_hf) begin
                        state_q <= st_startup;
                    end else if (changed) begin
                        state_q <= st_wait_new;
                    end
                end
                st_startup: begin
                    if (wait_cnt_q != STARTUP_LAST[WAIT_W-1:0]) begin
                        wait_cnt_q <= wait_cnt_q + 1'b1;
                    end else if (hf_osc_ready_in) begin
                        state_q <= st_edge;
                    end
                end
                st_wait_new: begin
                    if (new_tick) begin
                        state_q <= st_edge;
                    end
                end
                st_edge: begin
                    if (cur_tick) begin
                        cur_src_q <= pend_src_q;
                        cur_shift_q <= pend_shift_q;
                        state_q <= st_run;
                    end
                end
            endcase
        end
    end

    // Outputs are registered so the tick never glitches on a mux change.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sys_tick_q <= 1'b0;
            hf_en_q <= 1'b0;
            lf_en_q <= 1'b0;
        end else begin
            sys_tick_q <= cur_tick & (state_q != st_boot);
            hf_en_q <= (cur_src_q == src_hf) | ((state_q != st_run) & (pend_src_q == src_hf));
            lf_en_q <= (cur_src_q == src_lf) | ((state_q != st_run) & (pend_src_q == src_lf));
        end
    end

    assign sys_clk_tick = sys_tick_q;
    assign active_source = cur_src_q;
    assign switch_busy = (state_q != st_run);
    assign hf_osc_enable = hf_en_q;
    assign lf_osc_enable = lf_en_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_sel_ext_pick: assert property (
        (sel_q == `SEL_CONFIG && config_osc_select != `CFG_INTERNAL) |-> tgt_src == src_ext)
        else $error("config select did not pick external clock");
    chk_int_freq_use: assert property (
        (sel_q[1] && freq_q == 4'hF) |-> (tgt_src == src_hf && tgt_shift == 4'h0))
        else $error("internal select not on fast clock");
    chk_sel_reset_zero: assert property (
        $past(sys_rst) |-> sel_q == `SEL_RESET)
        else $error("select field not cleared by reset");
    chk_code_one_mhz: assert property (
        (freq_q == 4'hB) |-> want_shift == 4'h4)
        else $error("1 MHz code wrong divider");
    chk_dup_code_div: assert property (
        (freq_q == 4'hA) |-> want_shift == 4'h5)
        else $error("duplicate 500 kHz code wrong divider");
    chk_freq_reset_val: assert property (
        $past(sys_rst) |-> freq_q == `FREQ_RESET)
        else $error("frequency field not 0111 after reset");
    chk_lf_code_pick: assert property (
        (sel_q[1] && freq_q[3:1] == 3'h0) |-> tgt_src == src_lf)
        else $error("000x did not pick slow oscillator");
    chk_hf_startup_wait: assert property (
        (state_q == st_edge && $past(state_q) == st_startup) |->
            $past(wait_cnt_q) == STARTUP_LAST[WAIT_W-1:0])
        else $error("fast oscillator start-up cut short");
    chk_stat_lf_rd: assert property (
        (reg_rd && stat_sel) |=> reg_rdata[1] == $past(lf_osc_ready_in))
        else $error("slow ready bit misread");
    chk_stat_hf_stable: assert property (
        (reg_rd && stat_sel) |=> reg_rdata[0] == $past(hf_osc_stable_in))
        else $error("fast stable bit misread");
    chk_stat_reserved_zero: assert property (
        (reg_rd && stat_sel) |=> (reg_rdata[7:5] == 3'h0 && reg_rdata[3:2] == 2'h0 &&
            reg_rdata[4] == $past(hf_osc_ready_in)))
        else $error("status reserved bits not zero");
    chk_commit_on_edge: assert property (
        ($past(state_q) == st_edge && state_q == st_run) |-> $past(cur_tick))
        else $error("switch completed off a clock edge");
    chk_same_src_fast: assert property (
        (state_q == st_run && changed && tgt_src == cur_src_q) |=> state_q == st_edge)
        else $error("same-source change took a start-up delay");
    chk_rsvd_hold_src: assert property (
        (ctrl_wr && reg_wdata[1:0] == `SEL_RSVD) |=> ##1 tgt_src == $past(tgt_src, 2))
        else $error("reserved select changed source");
    chk_ctrl_unimpl_zero: assert property (
        (reg_rd && ctrl_sel) |=> (reg_rdata[7] == 1'b0 && reg_rdata[2] == 1'b0))
        else $error("unimplemented control bits not zero");

    cov_hf_switch: cover property (state_q == st_startup ##[1:200] state_q == st_run);
    cov_lf_switch: cover property (state_q == st_wait_new && pend_src_q == src_lf);
    cov_rsvd_write: cover property (ctrl_wr && reg_wdata[1:0] == `SEL_RSVD);
endmodule

// *** test/osc_sources.sv ***
/*
 * Behavioural model of the clock sources behind the switch: a free-running
 * external clock and the fast and slow internal oscillators, each seen as
 * a one-cycle tick marking its falling edge.
 * Assumes the switch requests each internal oscillator by its enable and
 * that all periods are counted in core_clk cycles.
 */
`timescale 1ns/1ps

module osc_sources #(
    parameter int EXT_P = 6,
    parameter int HF_P = 2,
    parameter int LF_P = 32,
    parameter int HF_RDY = 20,
    parameter int HF_STB = 40,
    parameter int LF_RDY = 4
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic hf_osc_enable,
    input wire logic lf_osc_enable,
    output logic ext_clk_tick,
    output logic hf_osc_tick,
    output logic lf_osc_tick,
    output logic hf_osc_ready_in,
    output logic hf_osc_stable_in,
    output logic lf_osc_ready_in
);
    int ext_q;
    int hf_q;
    int lf_q;
    int hf_up_q;
    int lf_up_q;

    // ------------------------------------------------------------------
    // Status levels
    // ------------------------------------------------------------------
    // An oscillator that is not requested falls back to not ready at once.
    assign hf_osc_ready_in = (hf_up_q >= HF_RDY);
    assign hf_osc_stable_in = (hf_up_q >= HF_STB);
    assign lf_osc_ready_in = (lf_up_q >= LF_RDY);

    // ------------------------------------------------------------------
    // Oscillator phases and ticks
    // ------------------------------------------------------------------
    // The internal oscillators give no ticks until they are ready, so a
    // switch that forgets to wait for start-up stalls and is seen.
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_q <= 0;
            hf_q <= 0;
            lf_q <= 0;
            hf_up_q <= 0;
            lf_up_q <= 0;
            ext_clk_tick <= 1'b0;
            hf_osc_tick <= 1'b0;
            lf_osc_tick <= 1'b0;
        end else begin
            ext_q <= (ext_q + 1) % EXT_P;
            hf_q <= (hf_q + 1) % HF_P;
            lf_q <= (lf_q + 1) % LF_P;
            hf_up_q <= hf_osc_enable ? hf_up_q + (hf_up_q < HF_STB) : 0;
            lf_up_q <= lf_osc_enable ? lf_up_q + (lf_up_q < LF_RDY) : 0;
            ext_clk_tick <= (ext_q == 0);
            hf_osc_tick <= hf_osc_ready_in && (hf_q == 0);
            lf_osc_tick <= lf_osc_ready_in && (lf_q == 0);
        end
    end
endmodule

// *** test/system_clock_switch_select_tb.sv ***
/*
 * Self-checking bench for the system clock switch: register access,
 * source and frequency selection, switch timing and reset values.
 * Assumes the oscillator model above and the register bus of the switch.
 */
`timescale 1ns/1ps
`include "clk_switch_params.svh"

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end

module system_clock_switch_select_tb;
    import clk_switch_pkg::*;
    localparam int EXT_P = 6;
    localparam int HF_P = 2;
    localparam int LF_P = 32;
    logic core_clk, sys_rst, reg_wr, reg_rd, sys_clk_tick, switch_busy;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, stat_snap, d;
    logic [1:0] config_osc_select;
    logic ext_clk_tick, hf_osc_tick, lf_osc_tick, hf_osc_enable, lf_osc_enable;
    logic hf_osc_ready_in, hf_osc_stable_in, lf_osc_ready_in;
    clk_src_type active_source;
    int err_count = 0;
    int n_compared = 0;
    int bn, p, i, c;

    clk_switch dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .config_osc_select(config_osc_select), .ext_clk_tick(ext_clk_tick),
        .hf_osc_tick(hf_osc_tick), .lf_osc_tick(lf_osc_tick),
        .hf_osc_ready_in(hf_osc_ready_in), .hf_osc_stable_in(hf_osc_stable_in),
        .lf_osc_ready_in(lf_osc_ready_in), .sys_clk_tick(sys_clk_tick),
        .active_source(active_source), .switch_busy(switch_busy),
        .hf_osc_enable(hf_osc_enable), .lf_osc_enable(lf_osc_enable));

    osc_sources #(.EXT_P(EXT_P), .HF_P(HF_P), .LF_P(LF_P)) osc_u (.core_clk(core_clk),
        .sys_rst(sys_rst), .hf_osc_enable(hf_osc_enable), .lf_osc_enable(lf_osc_enable),
        .ext_clk_tick(ext_clk_tick), .hf_osc_tick(hf_osc_tick), .lf_osc_tick(lf_osc_tick),
        .hf_osc_ready_in(hf_osc_ready_in), .hf_osc_stable_in(hf_osc_stable_in),
        .lf_osc_ready_in(lf_osc_ready_in));

    // ------------------------------------------------------------------
    // Clock, watchdog and verdict
    // ------------------------------------------------------------------
    // The clock runs at 40 MHz; the watchdog sits well past the longest run.
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        repeat (90000) @(posedge core_clk);
        err_count++;
        $display("ERROR t=%0t watchdog got %h exp %h", $time, 1'b1, 1'b0);
        final_report;
    end

    task final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Bus tasks and measurements
    // ------------------------------------------------------------------
    // Status levels are captured while the read strobe stands, because the
    // switch samples them at the edge that takes the read.
    task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        #1 stat_snap = {3'h0, hf_osc_ready_in, 2'h0, lf_osc_ready_in, hf_osc_stable_in};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Counts busy cycles until the switch is back in run, with a bound.
    task automatic wait_idle(output int n);
        int k;
        n = 0;
        for (k = 0; k < 5000; k++) begin
            @(posedge core_clk);
            #1;
            if (switch_busy === 1'b1) n++;
            else if (k > 3) break;
        end
    endtask

    // Cycles between the second and third system tick after the call.
    task automatic measure(output int n);
        int k, seen;
        n = 0;
        seen = 0;
        for (k = 0; k < 5000 && seen < 3; k++) begin
            @(posedge core_clk);
            #1;
            if (seen == 2) n++;
            if (sys_clk_tick === 1'b1) seen++;
        end
    endtask

    function automatic int exp_period(input logic [3:0] code);
        int n;
        case (code)
            4'hF: n = 0;
            4'hE: n = 1;
            4'hD: n = 2;
            4'hC: n = 3;
            4'hB: n = 4;
            4'hA, 4'h7: n = 5;
            4'h9, 4'h6: n = 6;
            4'h8, 4'h5: n = 7;
            4'h4: n = 8;
            default: n = 9;
        endcase
        return (code[3:1] == 3'h0) ? LF_P : (HF_P << n);
    endfunction

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        config_osc_select = 2'h0;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        wait_idle(bn);
        reg_read(`CTRL_ADDR, d);
        `CHK(d, 8'h38)
        `CHK(active_source, src_hf)
        measure(p);
        `CHK(p, exp_period(4'h7))
        reg_read(`STAT_ADDR, d);
        `CHK(d, stat_snap)
        reg_write(`STAT_ADDR, 8'hFF);
        reg_read(`STAT_ADDR, d);
        `CHK(d, stat_snap)
        reg_write(4'hF, 8'hFF);
        reg_read(4'hF, d);
        `CHK(d, 8'h00)
        reg_read(`CTRL_ADDR, d);
        `CHK(d, 8'h38)
        // Every frequency code in turn; bit 2 is set to show it is dropped.
        for (i = 15; i >= 0; i--) begin
            reg_write(`CTRL_ADDR, {1'b0, i[3:0], 3'h6});
            wait_idle(bn);
            if (i == 14) `CHK((bn < 80), 1'b1)
            measure(p);
            `CHK(p, exp_period(i[3:0]))
            `CHK(active_source, ((i < 2) ? src_lf : src_hf))
            `CHK({hf_osc_enable, lf_osc_enable}, ((i < 2) ? 2'b01 : 2'b10))
            reg_read(`CTRL_ADDR, d);
            `CHK(d, {1'b0, i[3:0], 3'h2})
            reg_read(`STAT_ADDR, d);
            `CHK(d, stat_snap)
        end
        // From the slow oscillator into the fast one needs the start-up wait.
        reg_write(`CTRL_ADDR, 8'h7A);
        wait_idle(bn);
        `CHK((bn >= 80), 1'b1)
        measure(p);
        `CHK(p, exp_period(4'hF))
        // External clock ranges through the configuration setting.
        for (c = 1; c < 4; c++) begin
            @(posedge core_clk);
            config_osc_select <= c[1:0];
            reg_write(`CTRL_ADDR, 8'h38);
            wait_idle(bn);
            `CHK(active_source, src_ext)
            measure(p);
            `CHK(p, EXT_P)
        end
        reg_write(`CTRL_ADDR, 8'h39);
        wait_idle(bn);
        `CHK(active_source, src_ext)
        reg_read(`CTRL_ADDR, d);
        `CHK(d, 8'h39)
        reg_write(`CTRL_ADDR, 8'h3A);
        wait_idle(bn);
        `CHK(active_source, src_hf)
        // A reset in mid-run brings both fields back.
        @(posedge core_clk);
        config_osc_select <= 2'h0;
        reg_write(`CTRL_ADDR, 8'h7A);
        wait_idle(bn);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        wait_idle(bn);
        reg_read(`CTRL_ADDR, d);
        `CHK(d, 8'h38)
        `CHK(active_source, src_hf)
        measure(p);
        `CHK(p, exp_period(4'h7))
        final_report;
    end
endmodule
